// *** modbus_mw_pkg.sv ***
package modbus_mw_pkg;
	// table sizes
	localparam int NUM_COILS = 256;
	localparam int NUM_REGS  = 64;
	localparam int BUF_BYTES = 128;
	localparam logic [16:0] COIL_LIMIT = 17'h0_0100;
	localparam logic [16:0] REG_LIMIT  = 17'h0_0040;
	localparam logic [15:0] MAX_COILS  = 16'h07B0;
	localparam logic [15:0] MAX_REGS   = 16'h003C;
	// frame layout
	localparam logic [7:0] POS_ADDR = 8'h00;
	localparam logic [7:0] POS_FUNC = 8'h01;
	localparam logic [7:0] POS_S_HI = 8'h02;
	localparam logic [7:0] POS_S_LO = 8'h03;
	localparam logic [7:0] POS_Q_HI = 8'h04;
	localparam logic [7:0] POS_Q_LO = 8'h05;
	localparam logic [7:0] POS_BCNT = 8'h06;
	localparam logic [7:0] HDR_LEN  = 8'h07;
	localparam logic [2:0] NORM_LEN = 3'h6;
	localparam logic [2:0] EXC_LEN  = 3'h3;
	// codes
	localparam logic [7:0] BCAST_ADDR   = 8'h00;
	localparam logic [7:0] FC_COILS     = 8'h0F;
	localparam logic [7:0] FC_REGS      = 8'h10;
	localparam logic [7:0] EXC_FLAG     = 8'h80;
	localparam logic [7:0] EXC_NONE     = 8'h00;
	localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
	localparam logic [7:0] EXC_ILL_VAL  = 8'h03;
	localparam logic [7:0] EXC_DEV_FAIL = 8'h04;
	// reset values
	localparam logic [15:0] REG_RST = 16'h0000;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic       err;
		logic [7:0] data;
	} rx_byte_t;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} tx_byte_t;

	typedef logic [NUM_REGS-1:0][15:0] hreg_bank_t;

	typedef enum logic [1:0] {S_RX, S_CHECK, S_WRITE, S_RESP} state_t;
endpackage

// *** modbus_mw_slave.sv ***
`timescale 1ns/1ns
// Overview of operation
// RULE_01: coil block written from packed data, one bit per coil, 1 on, 0 off.
// RULE_02: coil and register addresses in a request count from zero.
// RULE_03: coil write to slave address 0 is a broadcast and is applied.
// RULE_04: broadcast accepted only for codes 5, 6, 15, 16 and loopback.
// RULE_05: coil write reply: address, function, start, quantity; no coil data.
// RULE_06: coil writes happen whether or not coils are disabled.
// RULE_07: coils are not cleared at power-up or reset; they keep last value.
// RULE_08: register write loads consecutive holding registers, at most 60.
// RULE_09: master sends 16-bit values with unused high bits zero.
// RULE_10: register write reply: address, function, start, register count.
// RULE_11: each register travels high byte first, then low byte.
// RULE_12: a frame with a communication error is dropped with no reply.
// RULE_13: master times out when no reply arrives.
// RULE_14: a well-formed request that cannot be served gets an exception.
// RULE_15: exception reply returns function code with bit 7 set.
// RULE_16: request function codes lie below 80 hex; set bit marks exception.
// RULE_17: exception data field holds only the exception code.
// RULE_18: nonexistent location gives exception code 02.
// RULE_19: master reads the exception code to learn the failure.
// RULE_20: code 01 bad function, 03 bad value or structure, 04 device failure.
// RULE_21: requests for other slave addresses are ignored silently.
// RULE_22: broadcast writes are executed but never answered.
module modbus_mw_slave
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset,
	// own slave address
	input  wire logic [7:0]              own_addr,
	// received frame bytes, check field already removed
	input  wire modbus_mw_pkg::rx_byte_t rx,
	// response bytes
	input  wire logic                    tx_ready,
	output modbus_mw_pkg::tx_byte_t      tx,
	// data tables
	output logic [modbus_mw_pkg::NUM_COILS-1:0] coils,
	output modbus_mw_pkg::hreg_bank_t           holding
);
	import modbus_mw_pkg::*;

	state_t                 state_ff;
	logic   [7:0]           rx_cnt_ff;
	logic   [8:0]           len_ff;
	logic   [7:0]           addr_ff;
	logic   [7:0]           func_ff;
	logic   [15:0]          start_ff;
	logic   [15:0]          qty_ff;
	logic   [7:0]           bcnt_ff;
	logic   [7:0]           buf_ff [BUF_BYTES];
	logic   [7:0]           exc_ff;
	logic   [7:0]           k_ff;
	logic   [2:0]           out_cnt_ff;
	tx_byte_t               tx_ff;
	logic   [NUM_COILS-1:0] coils_ff;
	hreg_bank_t             holding_ff;
	logic   [7:0]           nxt_exc;
	logic   [15:0]          coil_bytes;
	logic   [16:0]          end_addr;
	logic                   len_ok;
	logic                   bcast;
	logic                   done_write;
	logic                   frame_end;
	logic                   frame_take;

	function automatic logic is_write_fc(input logic [7:0] f);
		return (f == FC_COILS) || (f == FC_REGS);
	endfunction

	function automatic logic [7:0] resp_byte(input logic [2:0] idx, input logic [7:0] a,
		input logic [7:0] f, input logic [7:0] e, input logic [15:0] s, input logic [15:0] q);
		logic [7:0] b;
		b = a;
		unique case (idx)
			3'h0: b = a;
			3'h1: b = (e != EXC_NONE) ? (f | EXC_FLAG) : f; // [RULE_15] [RULE_16]
			3'h2: b = (e != EXC_NONE) ? e : s[15:8];        // [RULE_17]
			3'h3: b = s[7:0];
			3'h4: b = q[15:8];
			3'h5: b = q[7:0];
			default: b = a;
		endcase
		return b;
	endfunction

	assign tx      = tx_ff;
	assign coils   = coils_ff;
	assign holding = holding_ff;

	assign bcast      = (addr_ff == BCAST_ADDR);
	assign frame_end  = (state_ff == S_RX) && rx.valid && rx.last;
	assign frame_take = frame_end && !rx.err && (rx_cnt_ff != POS_ADDR)
		&& ((addr_ff == own_addr) || (addr_ff == BCAST_ADDR)); // [RULE_12] [RULE_21]
	assign done_write = (state_ff == S_WRITE) && ({8'h00, k_ff} == qty_ff - 16'h0001);

	// request checking, structure before address
	always_comb
	begin
		coil_bytes = {3'b000, qty_ff[15:3]} + {15'h0000, |qty_ff[2:0]};
		end_addr   = {1'b0, start_ff} + {1'b0, qty_ff};
		len_ok     = len_ff == ({1'b0, HDR_LEN} + {1'b0, bcnt_ff});
		nxt_exc    = EXC_NONE;
		if (!is_write_fc(func_ff))
			nxt_exc = EXC_ILL_FUNC; // [RULE_20] [RULE_14]
		else if (func_ff == FC_COILS)
		begin
			if (qty_ff == 16'h0000 || qty_ff > MAX_COILS || !len_ok
				|| {8'h00, bcnt_ff} != coil_bytes)
				nxt_exc = EXC_ILL_VAL; // [RULE_20]
			else if (end_addr > COIL_LIMIT)
				nxt_exc = EXC_ILL_ADDR; // [RULE_18]
		end
		else
		begin
			if (qty_ff == 16'h0000 || qty_ff > MAX_REGS || !len_ok
				|| {8'h00, bcnt_ff} != {qty_ff[14:0], 1'b0})
				nxt_exc = EXC_ILL_VAL; // [RULE_08] [RULE_20]
			else if (end_addr > REG_LIMIT)
				nxt_exc = EXC_ILL_ADDR; // [RULE_18]
		end
	end

	// sequencing
	always_ff @(posedge clk)
	begin
		if (reset)
			state_ff <= S_RX;
		else
		begin
			unique case (state_ff)
				S_RX:
					if (frame_take)
						state_ff <= S_CHECK;
				S_CHECK:
					if (nxt_exc == EXC_NONE)
						state_ff <= S_WRITE; // [RULE_03]
					else if (bcast)
						state_ff <= S_RX; // [RULE_04] [RULE_22]
					else
						state_ff <= S_RESP; // [RULE_14]
				S_WRITE:
					if (done_write)
						state_ff <= bcast ? S_RX : S_RESP; // [RULE_22]
				S_RESP:
					if ((!tx_ff.valid || tx_ready)
						&& out_cnt_ff == ((exc_ff != EXC_NONE) ? EXC_LEN : NORM_LEN) - 3'h1)
						state_ff <= S_RX;
			endcase
		end
	end

	// frame capture
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rx_cnt_ff <= POS_ADDR;
			len_ff    <= 9'h000;
			addr_ff   <= BCAST_ADDR;
			func_ff   <= 8'h00;
			start_ff  <= 16'h0000;
			qty_ff    <= 16'h0000;
			bcnt_ff   <= 8'h00;
		end
		else if (state_ff == S_RX && rx.valid)
		begin
			rx_cnt_ff <= rx.last ? POS_ADDR : rx_cnt_ff + {7'h00, rx_cnt_ff != 8'hFF};
			if (rx.last)
				len_ff <= {1'b0, rx_cnt_ff} + 9'h001;
			unique case (rx_cnt_ff)
				POS_ADDR: addr_ff <= rx.data;
				POS_FUNC: func_ff <= rx.data;
				POS_S_HI: start_ff[15:8] <= rx.data; // [RULE_02]
				POS_S_LO: start_ff[7:0] <= rx.data;
				POS_Q_HI: qty_ff[15:8] <= rx.data;
				POS_Q_LO: qty_ff[7:0] <= rx.data;
				POS_BCNT: bcnt_ff <= rx.data;
				default: ;
			endcase
		end
	end

	// data bytes, kept until the whole frame is known good
	always_ff @(posedge clk)
	begin
		if (state_ff == S_RX && rx.valid && rx_cnt_ff >= HDR_LEN
			&& rx_cnt_ff < HDR_LEN + 8'(BUF_BYTES))
			buf_ff[7'(rx_cnt_ff - HDR_LEN)] <= rx.data;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			exc_ff <= EXC_NONE;
		else if (state_ff == S_CHECK)
			exc_ff <= nxt_exc;
	end

	always_ff @(posedge clk)
	begin
		if (reset || state_ff != S_WRITE)
			k_ff <= 8'h00;
		else
			k_ff <= k_ff + 8'h01;
	end

	// coils hold their value through reset, disabled or not
	always_ff @(posedge clk)
	begin
		if (state_ff == S_WRITE && func_ff == FC_COILS)
			coils_ff[start_ff[7:0] + k_ff] <=
				buf_ff[{2'b00, k_ff[7:3]}][k_ff[2:0]]; // [RULE_01] [RULE_06] [RULE_07]
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			holding_ff <= {NUM_REGS{REG_RST}};
		else if (state_ff == S_WRITE && func_ff == FC_REGS)
			holding_ff[start_ff[5:0] + k_ff[5:0]] <=
				{buf_ff[{k_ff[5:0], 1'b0}], buf_ff[{k_ff[5:0], 1'b1}]}; // [RULE_08] [RULE_11]
	end

	// reply stream
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tx_ff      <= '0;
			out_cnt_ff <= 3'h0;
		end
		else
		begin
			if (state_ff != S_RESP)
				out_cnt_ff <= 3'h0;
			if (!tx_ff.valid || tx_ready)
			begin
				if (state_ff == S_RESP)
				begin
					tx_ff.valid <= 1'b1;
					tx_ff.data  <= resp_byte(out_cnt_ff, addr_ff, func_ff, exc_ff, start_ff,
						qty_ff); // [RULE_05] [RULE_10]
					tx_ff.last  <= out_cnt_ff ==
						((exc_ff != EXC_NONE) ? EXC_LEN : NORM_LEN) - 3'h1; // [RULE_17]
					out_cnt_ff  <= out_cnt_ff + 3'h1;
				end
				else
					tx_ff <= '0;
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_check_bcast;
		state_ff == S_CHECK && bcast;
	endsequence

	sequence s_check_unicast_bad;
		state_ff == S_CHECK && !bcast && nxt_exc != EXC_NONE;
	endsequence

	sequence s_addr_byte_out;
		tx_ff.valid && tx_ff.data == own_addr ##[0:8] tx_ff.valid && tx_ready;
	endsequence

	a_err_drop: assert property (frame_end && rx.err |=> state_ff == S_RX) // [RULE_12]
		else $error("errored frame was not dropped");
	a_addr_filter: assert property (frame_end && addr_ff != own_addr // [RULE_21]
		&& addr_ff != BCAST_ADDR |=> state_ff == S_RX)
		else $error("foreign address accepted");
	a_bcast_silent: assert property (s_check_bcast |=> state_ff != S_RESP) // [RULE_22]
		else $error("broadcast answered");
	a_bcast_apply: assert property (state_ff == S_CHECK && bcast // [RULE_03]
		&& nxt_exc == EXC_NONE |=> state_ff == S_WRITE)
		else $error("good broadcast write not applied");
	a_bad_func: assert property (state_ff == S_CHECK && !bcast // [RULE_20]
		&& !is_write_fc(func_ff) |=> state_ff == S_RESP && exc_ff == EXC_ILL_FUNC)
		else $error("unsupported function not refused with 01");
	a_exc_resp: assert property (s_check_unicast_bad ##1 state_ff == S_RESP // [RULE_15]
		|-> ##[1:2] s_addr_byte_out ##1 tx_ff.data == (func_ff | EXC_FLAG))
		else $error("exception function byte wrong");
	a_reg_limit: assert property (state_ff == S_CHECK && func_ff == FC_REGS // [RULE_08]
		&& qty_ff > MAX_REGS |=> state_ff != S_WRITE)
		else $error("more than 60 registers accepted");
	a_addr_range: assert property (state_ff == S_CHECK && is_write_fc(func_ff) // [RULE_18]
		&& end_addr > ((func_ff == FC_COILS) ? COIL_LIMIT : REG_LIMIT)
		|=> state_ff != S_WRITE && (bcast || exc_ff != EXC_NONE))
		else $error("out of range write accepted");
	a_coil_write: assert property (state_ff == S_WRITE && func_ff == FC_COILS // [RULE_01]
		|=> coils_ff[start_ff[7:0] + $past(k_ff)]
		== $past(buf_ff[{2'b00, k_ff[7:3]}][k_ff[2:0]]))
		else $error("coil not written from packed bit");
	a_reg_order: assert property (state_ff == S_WRITE && func_ff == FC_REGS // [RULE_11]
		|=> holding_ff[start_ff[5:0] + $past(k_ff[5:0])]
		== {$past(buf_ff[{k_ff[5:0], 1'b0}]), $past(buf_ff[{k_ff[5:0], 1'b1}])})
		else $error("register bytes not high then low");
	a_resp_last: assert property (tx_ff.valid && tx_ff.last && exc_ff == EXC_NONE // [RULE_05]
		|-> $past(out_cnt_ff) == NORM_LEN - 3'h1 || $past(tx_ff.valid && !tx_ready))
		else $error("normal reply length wrong");
	a_tx_hold: assert property (tx_ff.valid && !tx_ready // [RULE_10]
		|=> tx_ff.valid && $stable(tx_ff.data) && $stable(tx_ff.last))
		else $error("reply byte changed before it was taken");
endmodule

// *** modbus_mw_master.sv ***
`timescale 1ns/1ns
module modbus_mw_master
(
	// clock
	input  wire logic                    clk,
	// sink stall control
	input  wire logic                    slow,
	// slave side
	output modbus_mw_pkg::rx_byte_t      rx,
	output logic                         tx_ready,
	input  wire modbus_mw_pkg::tx_byte_t tx
);
	import modbus_mw_pkg::*;
	logic [7:0] rsp [$];
	logic       done;
	initial
	begin
		rx = '0;
		tx_ready = 1'b0;
		done = 1'b0;
	end
	// reply bytes are taken at the handshake edge
	always @(posedge clk)
	begin
		if (tx.valid === 1'b1 && tx_ready === 1'b1)
		begin
			rsp.push_back(tx.data);
			if (tx.last === 1'b1)
				done <= 1'b1;
		end
	end
	// a slow sink accepts every other cycle
	always @(negedge clk)
		tx_ready <= slow ? ~tx_ready : 1'b1;
	// bytes go out whole, register values high byte first
	task automatic send(input logic [7:0] b [$], input logic e);
		rsp.delete();
		done = 1'b0;
		foreach (b[i])
		begin
			@(negedge clk);
			rx <= {1'b1, i == b.size() - 1, e && i == b.size() - 1, b[i]};
		end
		@(negedge clk);
		rx <= {3'b000, ~rx.data};
	endtask
endmodule

// *** modbus_mw_slave_tb_top.sv ***
`timescale 1ns/1ns
module modbus_mw_slave_tb_top;
	import modbus_mw_pkg::*;
	logic                 clk = 1'b0;
	logic                 reset = 1'b1;
	logic                 slow = 1'b0;
	logic [7:0]           own_addr = 8'h11;
	rx_byte_t             rx;
	tx_byte_t             tx;
	logic                 tx_ready;
	logic [NUM_COILS-1:0] coils;
	hreg_bank_t           holding;
	int                   miscompares = 0;
	int                   n_compared = 0;
	logic [7:0]           q [$];
	logic [7:0]           no_rsp [$];
	always #5 clk = ~clk;
	modbus_mw_slave i_modbus_mw_slave (.clk(clk), .reset(reset), .own_addr(own_addr), .rx(rx),
		.tx_ready(tx_ready), .tx(tx), .coils(coils), .holding(holding));
	modbus_mw_master i_modbus_mw_master (.clk(clk), .slow(slow), .rx(rx), .tx_ready(tx_ready),
		.tx(tx));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// a frame with no reply is given the whole bounded wait
	task automatic run(input logic e, input logic [7:0] exp [$]);
		int n;
		i_modbus_mw_master.send(q, e);
		n = 0;
		while (i_modbus_mw_master.done !== 1'b1 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		@(negedge clk);
		chk(16'(i_modbus_mw_master.rsp.size()), 16'(exp.size()));
		chk({15'h0000, i_modbus_mw_master.done}, {15'h0000, exp.size() != 0});
		foreach (exp[i])
			if (i < i_modbus_mw_master.rsp.size())
				chk({8'h00, i_modbus_mw_master.rsp[i]}, {8'h00, exp[i]});
	endtask
	task automatic t_regs;
		slow <= 1'b1;
		q = '{8'h11, 8'h10, 8'h00, 8'h3E, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'h00, 8'h0A};
		run(1'b0, '{8'h11, 8'h10, 8'h00, 8'h3E, 8'h00, 8'h02});
		chk(holding[62], 16'h1234);
		chk(holding[63], 16'h000A);
		slow <= 1'b0;
	endtask
	task automatic t_coils;
		q = '{8'h00, 8'h0F, 8'h00, 8'h10, 8'h00, 8'h10, 8'h02, 8'hFF, 8'hFF};
		run(1'b0, no_rsp);
		q = '{8'h11, 8'h0F, 8'h00, 8'h13, 8'h00, 8'h0A, 8'h02, 8'hCD, 8'h01};
		run(1'b0, '{8'h11, 8'h0F, 8'h00, 8'h13, 8'h00, 8'h0A});
		chk(coils[31:16], 16'hEE6F);
	endtask
	task automatic t_exc;
		q = '{8'h11, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
		run(1'b0, '{8'h11, 8'h83, 8'h01});
		q = '{8'h11, 8'h10, 8'h00, 8'h00, 8'h00, 8'h3D, 8'h00};
		run(1'b0, '{8'h11, 8'h90, 8'h03});
		q = '{8'h11, 8'h10, 8'h00, 8'h3F, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
		run(1'b0, '{8'h11, 8'h90, 8'h02});
		q = '{8'h11, 8'h0F, 8'h00, 8'hFF, 8'h00, 8'h02, 8'h01, 8'h00};
		run(1'b0, '{8'h11, 8'h8F, 8'h02});
		chk(holding[63], 16'h000A);
	endtask
	task automatic t_silent;
		q = '{8'h11, 8'h10, 8'h00, 8'h3E, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
		run(1'b1, no_rsp);
		q[0] = 8'h12;
		run(1'b0, no_rsp);
		chk(holding[62], 16'h1234);
		q = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
		run(1'b0, no_rsp);
		q = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'hBE, 8'hEF};
		run(1'b0, no_rsp);
		chk(holding[0], 16'hBEEF);
	endtask
	task automatic t_reset;
		reset <= 1'b1;
		@(negedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk(holding[62], 16'h0000);
		chk(coils[31:16], 16'hEE6F);
	endtask
	task automatic print_verdict;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		miscompares++;
		print_verdict();
	end
	initial
	begin
		repeat (2) @(negedge clk);
		reset <= 1'b0;
		t_regs();
		t_coils();
		t_exc();
		t_silent();
		t_reset();
		print_verdict();
	end
endmodule
